// >>> logic/tqm_fifo.sv
`timescale 1ns/10ps

// Synchronous FIFO with valid/ready on both sides; read data is registered.
module tqm_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Status
  output logic [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign count     = cnt_r;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Head word held in a register; it follows the read pointer.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (push && (cnt_r == '0 || (pop && cnt_r == 1))) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= mem_r[rd_ptr_r + 1'b1];
    end
  end

endmodule

// >>> logic/tqm_pkg.sv
package tqm_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------------------
  localparam int          PKT_NUM_W    = 6;
  localparam int          NUM_PKTS     = 1 << PKT_NUM_W;
  localparam int          PAGE_W       = 7;
  localparam int          TOTAL_PAGES  = 32;
  localparam int          PAGE_BYTES   = 256;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          BYTES_W      = 11;
  localparam int          STAT_W       = 16;
  localparam logic [7:0]  PAGE_SHIFT   = 8'h08;
  localparam logic        TX_EN_RST    = 1'b0;
  localparam logic        AUTO_FREE_RST = 1'b0;

  // ---------------------------------------------------------------------------
  // Host command codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TQM_CMD_NOP     = 3'h0,
    TQM_CMD_ALLOC   = 3'h1,
    TQM_CMD_RELEASE = 3'h2,
    TQM_CMD_ENQUEUE = 3'h3,
    TQM_CMD_ACK     = 3'h4,
    TQM_CMD_RESET   = 3'h5
  } tqm_cmd_e;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                 valid;
    logic [2:0]           cmd;
    logic [BYTES_W-1:0]   bytes;
    logic [PKT_NUM_W-1:0] pkt;
  } tqm_cmd_s;

  typedef struct packed {
    logic                 ok;
    logic [STAT_W-1:0]    status;
  } tqm_done_s;

  typedef struct packed {
    logic                 write;
    logic [PKT_NUM_W-1:0] pkt;
    logic [STAT_W-1:0]    word;
  } tqm_stat_wr_s;

endpackage

// >>> logic/tqm_top.sv
`timescale 1ns/10ps

//
// Contract
// (RL1) Allocate command tries to reserve the requested bytes for one packet.
// (RL2) Successful allocation sets done flag and gives the packet number.
// (RL3) Host polls the done flag or waits for its interrupt; there is no allocation interrupt here, only alloc_done_flag.
// (RL4) Host sets packet number, pointer, then writes frame data.
// (RL5) Enqueue pushes the packet number register value into the transmit FIFO.
// (RL6) Packets go to the MAC only when enabled and deferral allows.
// (RL7) On completion the status word overwrites the packet's first word.
// (RL8) On completion the number moves into the completion FIFO.
// (RL9) Transmit interrupt is high while the completion FIFO is non-empty.
// (RL10) Failure sets event flag, clears transmit enable, halts the queue.
// (RL11) After failure the failed number shows at the FIFO ports output.
// (RL12) Host reads completed number; its status then becomes readable.
// (RL13) On success the host releases the packet to free its memory.
// (RL14) Acknowledge removes the head entry of the completion FIFO.
// (RL15) After failure host releases, or re-enables and re-enqueues.
// (RL16) With auto-free 0, memory stays allocated until explicit release.
// (RL17) With auto-free 1, pages are freed on completion; here only a successful completion frees them.
// (RL18) Drained event rises when all enqueued packets have finished.
// (RL19) Failed allocation keeps done flag clear until memory frees.
//
module tqm_top (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          nrst,
  // Host commands
  input  wire tqm_pkg::tqm_cmd_s             host_cmd,
  input  wire logic [tqm_pkg::PKT_NUM_W-1:0] pkt_num_reg,
  input  wire logic                          tx_enable_set,
  input  wire logic                          auto_free_cfg,
  input  wire logic                          drained_clear,
  // MAC side
  input  wire logic                          half_duplex,
  input  wire logic                          defer_ok,
  output logic                               mac_start_r,
  output logic [tqm_pkg::PKT_NUM_W-1:0]      mac_pkt_r,
  input  wire tqm_pkg::tqm_done_s            mac_done,
  input  wire logic                          mac_done_valid,
  // Packet memory status write
  output tqm_pkg::tqm_stat_wr_s              stat_wr_r,
  // Status to host
  output logic                               alloc_done_flag,
  output logic [tqm_pkg::PKT_NUM_W-1:0]      alloc_result_r,
  output logic                               alloc_failed_r,
  output logic                               tx_enable_bit,
  output logic                               tx_int_r,
  output logic                               tx_event_r,
  output logic [tqm_pkg::PKT_NUM_W-1:0]      fifo_ports_r,
  output logic                               fifo_ports_empty_r,
  output logic                               tx_queue_drained_flag,
  output logic [tqm_pkg::STAT_W-1:0]         port_status_register,
  output logic [tqm_pkg::TOTAL_PAGES:0]      free_pages_r,
  output logic                               txq_ready_r
);

  localparam int PW = tqm_pkg::PKT_NUM_W;
  localparam int NP = tqm_pkg::NUM_PKTS;
  localparam int CW = $clog2(tqm_pkg::FIFO_DEPTH) + 1;

  typedef enum logic [1:0] {
    TQM_IDLE,
    TQM_SEND,
    TQM_WAIT,
    TQM_HALT
  } tqm_state_e;

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  logic do_alloc;
  logic do_release;
  logic do_enqueue;
  logic do_ack;
  logic do_reset;

  assign do_alloc   = host_cmd.valid && host_cmd.cmd == tqm_pkg::TQM_CMD_ALLOC;
  assign do_release = host_cmd.valid &&
                      host_cmd.cmd == tqm_pkg::TQM_CMD_RELEASE;
  assign do_enqueue = host_cmd.valid &&
                      host_cmd.cmd == tqm_pkg::TQM_CMD_ENQUEUE;
  assign do_ack     = host_cmd.valid && host_cmd.cmd == tqm_pkg::TQM_CMD_ACK;
  assign do_reset   = host_cmd.valid && host_cmd.cmd == tqm_pkg::TQM_CMD_RESET;

  // ---------------------------------------------------------------------------
  // Page accounting per packet number
  // ---------------------------------------------------------------------------
  logic [NP-1:0]                  used_r;
  logic [tqm_pkg::PAGE_W-1:0]     pages_r [NP];
  logic                           pend_r;
  logic [tqm_pkg::PAGE_W-1:0]     pend_pages_r;
  logic [PW-1:0]                  free_num;
  logic                           have_num;
  logic                           grant;
  logic                           free_done;
  logic [PW-1:0]                  free_pkt;
  logic [tqm_pkg::PAGE_W-1:0]     req_pages;

  // Bytes round up to whole pages; a spare bit keeps the sum from wrapping.
  assign req_pages = tqm_pkg::PAGE_W'(({1'b0, host_cmd.bytes} +
                     (tqm_pkg::BYTES_W + 1)'(tqm_pkg::PAGE_BYTES - 1)) >>
                     tqm_pkg::PAGE_SHIFT);

  always_comb begin
    free_num = '0;
    have_num = 1'b0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (!used_r[i]) begin
        free_num = PW'(i);
        have_num = 1'b1;
      end
    end
  end

  // A pending request is granted once a number and enough pages exist.
  assign grant = pend_r && have_num &&
                 ({1'b0, free_pages_r} >= (tqm_pkg::TOTAL_PAGES + 1)'(
                 pend_pages_r));                                  // [RL1] [RL19]

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      pend_r       <= 1'b0;
      pend_pages_r <= '0;
    end else if (do_alloc) begin
      pend_r       <= 1'b1;                                       // [RL1]
      pend_pages_r <= req_pages;
    end else if (grant) begin
      pend_r       <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      alloc_done_flag <= 1'b0;
      alloc_result_r  <= '0;
      alloc_failed_r  <= 1'b0;
    end else if (grant) begin
      alloc_done_flag <= 1'b1;                                    // [RL2]
      alloc_result_r  <= free_num;                                // [RL2]
      alloc_failed_r  <= 1'b0;
    end else if (do_alloc) begin
      alloc_done_flag <= 1'b0;                                    // [RL19]
    end else if (pend_r) begin
      alloc_failed_r  <= 1'b1;                                    // [RL19]
    end
  end

  // Auto-free releases pages at successful completion; otherwise only the host does.
  assign free_done = mac_done_valid && mac_done.ok && auto_free_cfg; // [RL17]
  assign free_pkt  = do_release ? pkt_num_reg : mac_pkt_r;

  generate
    for (genvar g = 0; g < NP; g++) begin : g_pkt
      always_ff @(posedge clock) begin
        if (!nrst || do_reset) begin
          used_r[g]  <= 1'b0;
          pages_r[g] <= '0;
        end else if (grant && free_num == PW'(g)) begin
          used_r[g]  <= 1'b1;
          pages_r[g] <= pend_pages_r;
        end else if ((do_release || free_done) && free_pkt == PW'(g)) begin
          used_r[g]  <= 1'b0;                                     // [RL16]
        end
      end
    end
  endgenerate

  logic [tqm_pkg::TOTAL_PAGES:0] take_pages;
  logic [tqm_pkg::TOTAL_PAGES:0] give_pages;

  // A grant and a release can fall in one cycle; both must be counted.
  assign take_pages = grant ?
                      (tqm_pkg::TOTAL_PAGES + 1)'(pend_pages_r) : '0;
  assign give_pages = ((do_release || free_done) && used_r[free_pkt]) ?
                      (tqm_pkg::TOTAL_PAGES + 1)'(pages_r[free_pkt]) : '0;

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      free_pages_r <= (tqm_pkg::TOTAL_PAGES + 1)'(tqm_pkg::TOTAL_PAGES);
    end else begin
      free_pages_r <= free_pages_r - take_pages + give_pages;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit FIFO and completion FIFO
  // ---------------------------------------------------------------------------
  logic          txq_ready;
  logic          txq_valid;
  logic [PW-1:0] txq_head;
  logic          txq_pop;
  logic [CW-1:0] txq_count;
  logic          cq_in_ready;
  logic          cq_valid;
  logic [PW-1:0] cq_head;
  logic [CW-1:0] cq_count;

  tqm_fifo #(
    .WIDTH (PW),
    .DEPTH (tqm_pkg::FIFO_DEPTH)
  ) u_txq (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (do_reset),
    .in_valid  (do_enqueue),                                      // [RL5]
    .in_ready  (txq_ready),
    .in_data   (pkt_num_reg),                                     // [RL5]
    .out_valid (txq_valid),
    .out_ready (txq_pop),
    .out_data  (txq_head),
    .count     (txq_count)
  );

  tqm_fifo #(
    .WIDTH (PW),
    .DEPTH (tqm_pkg::FIFO_DEPTH)
  ) u_cq (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (do_reset),
    .in_valid  (txq_pop),                                         // [RL8]
    .in_ready  (cq_in_ready),
    .in_data   (txq_head),                                        // [RL8]
    .out_valid (cq_valid),
    .out_ready (do_ack),                                          // [RL14]
    .out_data  (cq_head),
    .count     (cq_count)
  );

  // ---------------------------------------------------------------------------
  // Transmit sequencer
  // ---------------------------------------------------------------------------
  tqm_state_e state_r;
  logic       may_send;
  logic       fail;

  assign may_send = tx_enable_bit && (!half_duplex || defer_ok);  // [RL6]
  assign fail     = state_r == TQM_WAIT && mac_done_valid && !mac_done.ok;
  // A completion moves the number only when the completion FIFO has room.
  assign txq_pop  = state_r == TQM_WAIT && mac_done_valid && cq_in_ready;

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      state_r     <= TQM_IDLE;
      mac_start_r <= 1'b0;
      mac_pkt_r   <= '0;
    end else begin
      mac_start_r <= 1'b0;
      case (state_r)
        TQM_IDLE: begin
          if (txq_valid && may_send) begin
            state_r <= TQM_SEND;
          end
        end
        TQM_SEND: begin
          // Enable and deferral are looked at again at the start itself.
          if (may_send) begin
            mac_start_r <= 1'b1;                                  // [RL6]
            mac_pkt_r   <= txq_head;
            state_r     <= TQM_WAIT;
          end else begin
            state_r     <= TQM_IDLE;
          end
        end
        TQM_WAIT: begin
          if (fail && cq_in_ready) begin
            state_r <= TQM_HALT;                                  // [RL10]
          end else if (txq_pop) begin
            state_r <= TQM_IDLE;
          end
        end
        TQM_HALT: begin
          if (tx_enable_bit) begin
            state_r <= TQM_IDLE;
          end
        end
        default: begin
          state_r <= TQM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_enable_bit <= tqm_pkg::TX_EN_RST;
    end else if (fail && cq_in_ready) begin
      tx_enable_bit <= 1'b0;                                      // [RL10]
    end else if (tx_enable_set) begin
      tx_enable_bit <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      tx_event_r <= 1'b0;
    end else if (fail && cq_in_ready) begin
      tx_event_r <= 1'b1;                                         // [RL10]
    end else if (tx_enable_set) begin
      tx_event_r <= 1'b0;
    end
  end

  // Status word goes to the packet's first memory word at completion.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stat_wr_r <= '0;
    end else begin
      stat_wr_r.write <= txq_pop;                                 // [RL7]
      stat_wr_r.pkt   <= mac_pkt_r;
      stat_wr_r.word  <= mac_done.status;                         // [RL7]
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      port_status_register <= '0;
    end else if (txq_pop) begin
      port_status_register <= mac_done.status;                    // [RL12]
    end
  end

  // ---------------------------------------------------------------------------
  // Host-visible queue state
  // ---------------------------------------------------------------------------
  logic [CW-1:0] cq_next;

  assign cq_next = cq_count + CW'(txq_pop) - CW'(do_ack && cq_valid);

  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      tx_int_r           <= 1'b0;
      fifo_ports_empty_r <= 1'b1;
      txq_ready_r        <= 1'b1;
    end else begin
      tx_int_r           <= cq_next != '0;                        // [RL9]
      fifo_ports_empty_r <= cq_next == '0;
      txq_ready_r        <= txq_count < CW'(tqm_pkg::FIFO_DEPTH - 1);
    end
  end

  // Failed number is shown directly and held while halted; otherwise the completion head.
  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      fifo_ports_r <= '0;
    end else if (fail && cq_in_ready) begin
      fifo_ports_r <= mac_pkt_r;                                  // [RL11]
    end else if (state_r != TQM_HALT) begin
      fifo_ports_r <= (txq_pop && !cq_valid) ? txq_head : cq_head; // [RL12]
    end
  end

  // Drained event: set wins over clear.
  always_ff @(posedge clock) begin
    if (!nrst || do_reset) begin
      tx_queue_drained_flag <= 1'b0;
    end else if (txq_pop && txq_count == CW'(1) && !do_enqueue) begin
      tx_queue_drained_flag <= 1'b1;                              // [RL18]
    end else if (drained_clear) begin
      tx_queue_drained_flag <= 1'b0;
    end
  end

endmodule

// >>> test/tqm_mac_model.sv
`timescale 1ns/10ps

// Sends each started packet after a short or long time; fails on command.
module tqm_mac_model (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        mac_start_r,
  input wire logic [5:0]  mac_pkt_r,
  input wire logic        fail_en,
  input wire logic [5:0]  fail_pkt,
  input wire logic        slow,
  output tqm_pkg::tqm_done_s mac_done,
  output logic            mac_done_valid
);
  logic [4:0] left_r;
  logic       busy_r;
  logic [5:0] pkt_r;
  logic       ok;
  assign ok = !(fail_en && pkt_r == fail_pkt);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      mac_done_valid <= 1'b0;
      mac_done <= '0;
    end else begin
      mac_done_valid <= 1'b0;
      mac_done <= ~mac_done;
      if (mac_start_r) begin
        busy_r <= 1'b1;
        pkt_r <= mac_pkt_r;
        left_r <= slow ? 5'h14 : 5'h03;
      end else if (busy_r && left_r == 0) begin
        busy_r <= 1'b0;
        mac_done_valid <= 1'b1;
        mac_done <= {ok, 4'ha, 5'h00, ok, pkt_r};
      end else if (busy_r) begin
        left_r <= left_r - 5'h01;
      end
    end
  end
endmodule

// >>> test/tqm_top_sva.sv
`timescale 1ns/10ps

module tqm_top_chk (
  input wire logic                         clock,
  input wire logic                         nrst,
  input wire tqm_pkg::tqm_cmd_s            host_cmd,
  input wire logic                         tx_enable_set,
  input wire logic                         auto_free_cfg,
  input wire logic                         half_duplex,
  input wire logic                         defer_ok,
  input wire logic                         mac_start_r,
  input wire logic [tqm_pkg::PKT_NUM_W-1:0] mac_pkt_r,
  input wire tqm_pkg::tqm_done_s           mac_done,
  input wire logic                         mac_done_valid,
  input wire tqm_pkg::tqm_stat_wr_s        stat_wr_r,
  input wire logic                         alloc_done_flag,
  input wire logic                         tx_enable_bit,
  input wire logic                         tx_int_r,
  input wire logic                         tx_event_r,
  input wire logic [tqm_pkg::PKT_NUM_W-1:0] fifo_ports_r,
  input wire logic [tqm_pkg::TOTAL_PAGES:0] free_pages_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_alloc_two_edges: assert property (
    host_cmd.valid && host_cmd.cmd == tqm_pkg::TQM_CMD_ALLOC &&
    host_cmd.bytes <= 11'h100 && free_pages_r != 0 ##1 !host_cmd.valid
    |=> alloc_done_flag) else $error("allocation not done in time");
  a_start_enabled: assert property (
    mac_start_r |-> $past(tx_enable_bit)) else $error("start while off");
  a_start_defer: assert property (
    mac_start_r |-> $past(!half_duplex || defer_ok))
    else $error("start while deferring");
  a_status_write: assert property (
    mac_done_valid |=> stat_wr_r.write &&
    stat_wr_r.word == $past(mac_done.status) &&
    stat_wr_r.pkt == $past(mac_pkt_r)) else $error("status write wrong");
  a_int_raised: assert property (
    stat_wr_r.write |-> tx_int_r) else $error("no transmit interrupt");
  a_int_held: assert property (
    tx_int_r && !host_cmd.valid |=> tx_int_r)
    else $error("interrupt dropped without ack");
  a_fail_stops: assert property (
    mac_done_valid && !mac_done.ok && !tx_enable_set |=> !tx_enable_bit &&
    tx_event_r && fifo_ports_r == $past(mac_pkt_r))
    else $error("failure not handled");
  a_halt_held: assert property (
    tx_event_r && !tx_enable_bit |-> !mac_start_r)
    else $error("sent after failure");
  a_keep_pages: assert property (
    !auto_free_cfg && mac_done_valid && !host_cmd.valid &&
    !$past(host_cmd.valid) |=> $stable(free_pages_r))
    else $error("pages freed without release");
endmodule

bind tqm_top tqm_top_chk tqm_top_chk_i (.clock(clock), .nrst(nrst),
  .host_cmd(host_cmd), .tx_enable_set(tx_enable_set),
  .auto_free_cfg(auto_free_cfg), .half_duplex(half_duplex),
  .defer_ok(defer_ok), .mac_start_r(mac_start_r), .mac_pkt_r(mac_pkt_r),
  .mac_done(mac_done), .mac_done_valid(mac_done_valid),
  .stat_wr_r(stat_wr_r), .alloc_done_flag(alloc_done_flag),
  .tx_enable_bit(tx_enable_bit), .tx_int_r(tx_int_r),
  .tx_event_r(tx_event_r), .fifo_ports_r(fifo_ports_r),
  .free_pages_r(free_pages_r));

// >>> test/tqm_top_test.sv
`timescale 1ns/10ps

module tqm_top_test;
  logic clock, nrst, tx_enable_set, auto_free_cfg, drained_clear;
  logic half_duplex, defer_ok, mac_start_r, mac_done_valid;
  logic alloc_done_flag, alloc_failed_r, tx_enable_bit, tx_int_r;
  logic tx_event_r, fifo_ports_empty_r, tx_queue_drained_flag;
  logic txq_ready_r, fail_en, slow;
  logic [5:0]  pkt_num_reg, mac_pkt_r, alloc_result_r, fifo_ports_r;
  logic [5:0]  fail_pkt;
  logic [15:0] port_status_register;
  logic [32:0] free_pages_r, fexp;
  logic [21:0] exp_q[$];
  tqm_pkg::tqm_cmd_s    host_cmd;
  tqm_pkg::tqm_done_s   mac_done;
  tqm_pkg::tqm_stat_wr_s stat_wr_r;
  int n_mismatch, comparisons, n_start, cycles, s, i;
  logic [31:0] seed;

  tqm_top tqm_top_i (.clock(clock), .nrst(nrst), .host_cmd(host_cmd),
    .pkt_num_reg(pkt_num_reg), .tx_enable_set(tx_enable_set),
    .auto_free_cfg(auto_free_cfg), .drained_clear(drained_clear),
    .half_duplex(half_duplex), .defer_ok(defer_ok),
    .mac_start_r(mac_start_r), .mac_pkt_r(mac_pkt_r), .mac_done(mac_done),
    .mac_done_valid(mac_done_valid), .stat_wr_r(stat_wr_r),
    .alloc_done_flag(alloc_done_flag), .alloc_result_r(alloc_result_r),
    .alloc_failed_r(alloc_failed_r), .tx_enable_bit(tx_enable_bit),
    .tx_int_r(tx_int_r), .tx_event_r(tx_event_r),
    .fifo_ports_r(fifo_ports_r), .fifo_ports_empty_r(fifo_ports_empty_r),
    .tx_queue_drained_flag(tx_queue_drained_flag),
    .port_status_register(port_status_register),
    .free_pages_r(free_pages_r), .txq_ready_r(txq_ready_r));
  tqm_mac_model tqm_mac_model_i (.clock(clock), .nrst(nrst),
    .mac_start_r(mac_start_r), .mac_pkt_r(mac_pkt_r), .fail_en(fail_en),
    .fail_pkt(fail_pkt), .slow(slow), .mac_done(mac_done),
    .mac_done_valid(mac_done_valid));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [2:0] c, input logic [10:0] b,
                     input logic [5:0] p);
    @(negedge clock);
    pkt_num_reg = p;
    host_cmd = {1'b1, c, b, 6'h00};
    @(negedge clock);
    host_cmd.valid = 1'b0;
  endtask

  task automatic pulse_en();
    @(negedge clock);
    tx_enable_set = 1'b1;
    @(negedge clock);
    tx_enable_set = 1'b0;
  endtask

  // The status word the MAC model reports, paired with its packet number.
  function automatic logic [21:0] ew(input logic ok, input logic [5:0] p);
    return {p, 4'ha, 5'h00, ok, p};
  endfunction

  task automatic wait_ack();
    for (int k = 0; k < 300 && tx_int_r !== 1'b1; k++) @(negedge clock);
    chk({tx_int_r, fifo_ports_empty_r}, 2'h2);
    cmd(tqm_pkg::TQM_CMD_ACK, 11'h000, 6'h00);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (mac_start_r === 1'b1) n_start++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  always @(negedge clock) begin
    if (nrst === 1'b1 && stat_wr_r.write === 1'b1) begin
      if (exp_q.size() == 0) chk(stat_wr_r.pkt, 33'h1ffffffff);
      else chk({stat_wr_r.pkt, stat_wr_r.word}, exp_q.pop_front());
    end
  end

  initial begin
    seed = 32'h5c829f0d;
    {nrst, tx_enable_set, auto_free_cfg, drained_clear} = 4'h0;
    {half_duplex, defer_ok, fail_en, slow} = 4'h0;
    {pkt_num_reg, fail_pkt} = 12'h000;
    host_cmd = '0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    chk({fifo_ports_empty_r, txq_ready_r, tx_enable_bit}, 3'h6);
    chk(free_pages_r, 33'd32);
    $display("test reset done");
    fexp = 33'd32;
    for (i = 0; i < 3; i++) begin
      cmd(tqm_pkg::TQM_CMD_ALLOC, i * 256 + 1 + ($random(seed) & 8'hff), 0);
      @(negedge clock);
      fexp = fexp - (i + 1);
      chk({alloc_done_flag, alloc_result_r}, {1'b1, 6'(i)});
      chk(free_pages_r, fexp);
    end
    $display("test alloc done");
    s = n_start;
    cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h00);
    repeat (10) @(negedge clock);
    chk(n_start, s);
    exp_q.push_back(ew(1'b1, 6'h00));
    pulse_en();
    wait_ack();
    chk({fifo_ports_r, port_status_register}, ew(1'b1, 0));
    chk(free_pages_r, fexp);
    chk({tx_int_r, fifo_ports_empty_r, tx_queue_drained_flag}, 3'h3);
    drained_clear = 1'b1;
    @(negedge clock);
    drained_clear = 1'b0;
    chk(tx_queue_drained_flag, 1'b0);
    cmd(tqm_pkg::TQM_CMD_RELEASE, 11'h000, 6'h00);
    repeat (3) @(negedge clock);
    fexp = fexp + 1;
    chk(free_pages_r, fexp);
    $display("test send done");
    {fail_en, fail_pkt} = {1'b1, 6'h01};
    exp_q.push_back(ew(1'b0, 6'h01));
    cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h01);
    cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h02);
    for (i = 0; i < 300 && tx_int_r !== 1'b1; i++) @(negedge clock);
    chk({tx_enable_bit, tx_event_r, fifo_ports_r}, 8'h41);
    s = n_start;
    repeat (20) @(negedge clock);
    chk(n_start, s);
    chk(port_status_register, 16'(ew(1'b0, 6'h01)));
    wait_ack();
    fail_en = 1'b0;
    exp_q.push_back(ew(1'b1, 6'h02));
    exp_q.push_back(ew(1'b1, 6'h01));
    pulse_en();
    wait_ack();
    cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h01);
    wait_ack();
    chk(exp_q.size(), 0);
    cmd(tqm_pkg::TQM_CMD_RELEASE, 11'h000, 6'h01);
    auto_free_cfg = 1'b1;
    exp_q.push_back(ew(1'b1, 6'h02));
    cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h02);
    wait_ack();
    repeat (3) @(negedge clock);
    chk(free_pages_r, 33'd32);
    $display("test failure done");
    auto_free_cfg = 1'b0;
    cmd(tqm_pkg::TQM_CMD_RESET, 11'h000, 6'h00);
    for (i = 0; i < 4; i++) cmd(tqm_pkg::TQM_CMD_ALLOC, 11'h7ff, 6'h00);
    @(negedge clock);
    chk(free_pages_r, 33'd0);
    cmd(tqm_pkg::TQM_CMD_ALLOC, 11'h001, 6'h00);
    repeat (10) @(negedge clock);
    chk({alloc_done_flag, alloc_failed_r}, 2'h1);
    cmd(tqm_pkg::TQM_CMD_RELEASE, 11'h000, 6'h03);
    repeat (10) @(negedge clock);
    chk({alloc_done_flag, alloc_failed_r}, 2'h2);
    $display("test refusal done");
    cmd(tqm_pkg::TQM_CMD_RESET, 11'h000, 6'h00);
    cmd(tqm_pkg::TQM_CMD_ALLOC, 11'h001, 6'h00);
    {half_duplex, slow} = 2'h3;
    s = n_start;
    for (i = 0; i < 17; i++) cmd(tqm_pkg::TQM_CMD_ENQUEUE, 11'h000, 6'h00);
    chk({txq_ready_r, n_start == s}, 2'h1);
    for (i = 0; i < 16; i++) exp_q.push_back(ew(1'b1, 6'h00));
    defer_ok = 1'b1;
    for (i = 0; i < 16; i++) wait_ack();
    chk({n_start - s, tx_queue_drained_flag}, {32'd16, 1'b1});
    chk(exp_q.size(), 0);
    $display("test queue full done");
    results();
  end
endmodule
